// file: ptp_onthefly_packet_modifier_tb.sv
// self-checking bench for the ptp on-the-fly packet modifier
`timescale 1ns/1ns
`default_nettype none
module ptp_onthefly_packet_modifier_tb import ptpm_pkg::*;;
   // ****************************************
   // harness and shared tasks
   // ****************************************
   logic core_clk = 0, srst = 1, hsel = 0, hwrite = 0, go = 0, sel = 0;
   logic [31:0] haddr = '0, hwdata = '0, rd, hrdata;
   logic [1:0] htrans = '0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp;
   ptpm_beat_type ing_in, eg_in, ing_out, eg_out;
   ptpm_class_type ing_cls = '0, eg_cls = '0;
   logic [47:0] tod_sec = 48'h0102_0304_0507;
   logic [29:0] tod_ns = 30'h1ABC_DEF0;
   logic [7:0] frm [0:71];
   logic [7:0] exp_b [0:71];
   int miscompares = 0, num_checks = 0;
   always #4 core_clk = ~core_clk;
   ptpm_modifier uut (.core_clk(core_clk), .srst(srst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .ing_in(ing_in), .ing_cls(ing_cls),
      .ing_out(ing_out), .eg_in(eg_in), .eg_cls(eg_cls), .eg_out(eg_out),
      .tod_sec(tod_sec), .tod_ns(tod_ns));
   ptpm_far_model m (.core_clk(core_clk), .go(go), .sel(sel),
      .ing_src(ing_in), .eg_src(eg_in), .ing_snk(ing_out), .eg_snk(eg_out));
   task automatic chk(input logic [63:0] got, input logic [63:0] want);
      num_checks++;
      if (got !== want) begin
         miscompares++;
         $display("ERROR at %0t: got %h expected %h", $time, got, want);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         miscompares++;
         print_verdict();
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic cfg(input logic [31:0] c, input logic [31:0] p);
      ahb(1'b1, A_CTRL, c | 32'h0000_0001);
      ahb(1'b1, A_PLACE, p);
      ahb(1'b1, A_CTRL, c);
   endtask
   function automatic ptpm_class_type cl(input logic u4, u6, ce, q, v2,
      input logic [2:0] t);
      return '{u4, u6, ce, q, v2, t, 8'h0E};
   endfunction
   function automatic logic [31:0] crc(input logic [7:0] a [0:71]);
      logic [31:0] c;
      c = '1;
      for (int i = 0; i < 68; i++) begin
         c = c ^ {24'h0, a[i]};
         for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ 32'hEDB8_8320 : c >> 1;
      end
      return ~c;
   endfunction
   task automatic put(input int p, input logic [63:0] v, input int n);
      for (int k = 0; k < n; k++) exp_b[p + k] = 8'(v >> (8 * (n - 1 - k)));
   endtask
   // header at byte 14, correction bytes 22..29, flags byte 20
   task automatic mk(input logic [63:0] cf);
      for (int i = 0; i < 68; i++) frm[i] = 8'(i) ^ 8'h5A;
      for (int k = 0; k < 8; k++) frm[22 + k] = cf[63 - 8 * k -: 8];
      frm[20] = 8'h00;
      {frm[71], frm[70], frm[69], frm[68]} = crc(frm);
      for (int i = 0; i < 72; i++) exp_b[i] = frm[i];
   endtask
   task automatic run(input logic d, input int lat);
      int n;
      for (int i = 0; i < 72; i++) m.tx[i] = frm[i];
      sel <= d;
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      // let the model's restart of its sink index land before polling it
      @(posedge core_clk);
      n = 0;
      while (m.ri < 72 && n < 300) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 300) begin
         miscompares++;
         print_verdict();
      end
      chk(m.lat, lat);
      for (int i = 0; i < 68; i++) chk(m.rx[i], exp_b[i]);
   endtask
   task automatic fcs_ok();
      chk({m.rx[71], m.rx[70], m.rx[69], m.rx[68]}, crc(m.rx));
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic s_regs();
      ahb(1'b0, A_CTRL, 32'h0);
      chk(rd, 32'h0);
      ahb(1'b1, A_CTRL, 32'hFFFF_FFFF);
      ahb(1'b0, A_CTRL, 32'h0);
      chk(rd, CTRL_MASK);
      ahb(1'b1, A_STAT, 32'hFFFF_FFFF);
      ahb(1'b0, A_STAT, 32'h0);
      chk(rd[1:0], 2'h3);
      ahb(1'b1, A_PLACE, 32'hFFFF_FFFF);
      ahb(1'b0, A_PLACE, 32'h0);
      chk(rd, PLACE_MASK);
      ahb(1'b0, 8'h10, 32'h0);
      chk(rd, 32'h0);
   endtask
   task automatic s_bypass();
      ing_cls <= cl(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, MT_SYNC);
      eg_cls <= cl(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, MT_SYNC);
      cfg(32'h0, 32'h0);
      mk(64'h0);
      run(1'b0, 1);
      run(1'b1, 1);
   endtask
   task automatic s_ingress();
      int n;
      ing_cls <= cl(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, MT_SYNC);
      for (int s = 0; s < 4; s++) begin
         cfg(32'h0000_0100, 32'h1001_1600 | 32'(s));
         n = (s == 3) ? 6 : s * s;
         mk(64'h0);
         put(12, 64'h0, 2);
         put(36, tod_sec, n);
         put(30, tod_ns, 4);
         run(1'b0, 41);
         fcs_ok();
      end
   endtask
   task automatic s_udp();
      ing_cls <= cl(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, MT_SYNC);
      cfg(32'h0000_0100, 32'h1001_1603);
      mk(64'h0);
      put(12, 64'h0, 2);
      run(1'b0, 41);
      fcs_ok();
      ing_cls <= cl(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, MT_SYNC);
      cfg(32'h0000_0102, 32'h1001_1603);
      run(1'b0, 41);
   endtask
   task automatic s_bad_v1u6();
      ing_cls <= cl(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, MT_SYNC);
      cfg(32'h0000_0100, 32'h0);
      mk(64'h0);
      put(12, 64'h0, 2);
      frm[68] = frm[68] ^ 8'hFF;
      run(1'b0, 41);
      chk({m.rx[71], m.rx[70], m.rx[69], m.rx[68]},
          {frm[71], frm[70], frm[69], frm[68]});
      eg_cls <= cl(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, MT_SYNC);
      cfg(32'h0000_1000, 32'h1001_1603);
      mk(64'h0);
      run(1'b1, 41);
   endtask
   task automatic s_egress();
      for (int v = 1; v >= 0; v--) begin
         eg_cls <= cl(1'b0, 1'b0, 1'b0, 1'b1, v[0], MT_SYNC);
         cfg(32'h0000_1000, 32'h0);
         mk(64'h0);
         put(v ? 48 : 54, v ? tod_sec : tod_sec[31:0], v ? 6 : 4);
         put(v ? 54 : 58, tod_ns, 4);
         run(1'b1, 41);
         fcs_ok();
      end
      eg_cls <= cl(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 3'h1);
      cfg(32'h0000_0004, 32'h1001_1603);
      mk(64'h0);
      put(36, 64'h0, 6);
      put(30, 64'h0, 4);
      run(1'b1, 41);
   endtask
   task automatic cf_case(input logic [31:0] c, input logic [2:0] t,
      input logic v2, input logic [63:0] cin, input logic [63:0] cexp);
      eg_cls <= cl(1'b0, 1'b0, 1'b0, 1'b1, v2, t);
      cfg(c, 32'h0);
      mk(cin);
      put(22, cexp, 8);
      run(1'b1, 41);
      fcs_ok();
   endtask
   task automatic s_cf();
      logic [63:0] add;
      logic [63:0] got_cf;
      logic [47:0] sw_sec;
      int sd;
      add = ({60'h0, tod_sec[3:0]} * NS_PER_SEC + {34'h0, tod_ns}) << 16;
      sw_sec = tod_sec;
      cf_case(32'h0000_2000, 3'h1, 1'b1, 64'h0, add);
      got_cf = {m.rx[22], m.rx[23], m.rx[24], m.rx[25],
                m.rx[26], m.rx[27], m.rx[28], m.rx[29]};
      sd = int'((got_cf >> CF_FRAC) / NS_PER_SEC) - int'(sw_sec[3:0]);
      if (sd < 0) sd = sd + 16;
      chk(64'(sw_sec + 48'(sd)), 64'(tod_sec));
      cf_case(32'h0000_4000, MT_PDREQ, 1'b1, 64'h1_0000, add + 64'h1_0000);
      cf_case(32'h0000_2000, 3'h1, 1'b1, CF_MAX, CF_MAX);
      cf_case(32'h0000_2000, 3'h1, 1'b1, CF_MAX - 64'h1, CF_MAX);
      cf_case(32'h0000_2000, 3'h1, 1'b0, 64'h0, 64'h0);
   endtask
   task automatic s_pdelay();
      ing_cls <= cl(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, MT_PDREQ);
      cfg(32'h0000_0400, 32'h0);
      mk(64'h0);
      run(1'b0, 41);
      ahb(1'b0, A_PDNS, 32'h0);
      chk(rd, {2'h0, tod_ns});
      ahb(1'b0, A_STAT, 32'h0);
      chk(rd[7:4], tod_sec[3:0]);
      tod_sec <= tod_sec + 48'h1;
      tod_ns <= tod_ns + 30'h3E8;
      cf_case(32'h0000_8000, MT_PDRESP, 1'b1, 64'h0,
              (NS_PER_SEC + 64'h3E8) << 16);
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      s_regs();
      s_bypass();
      s_ingress();
      s_udp();
      s_bad_v1u6();
      s_egress();
      s_cf();
      s_pdelay();
      print_verdict();
   end
endmodule // ptp_onthefly_packet_modifier_tb
`default_nettype wire

// file: ptpm_far_model.sv
// far-side stream model: frame source and sink for either byte path
`timescale 1ns/1ns
`default_nettype none
module ptpm_far_model import ptpm_pkg::*; (
   input wire logic core_clk,
   input wire logic go,
   input wire logic sel,
   output var ptpm_beat_type ing_src,
   output var ptpm_beat_type eg_src,
   input wire ptpm_beat_type ing_snk,
   input wire ptpm_beat_type eg_snk
);
   // ****************************************
   // source and sink
   // ****************************************
   logic [7:0] tx [0:71];
   logic [7:0] rx [0:71];
   int ti = 72;
   int ri = 72;
   int cyc = 0;
   int t0 = 0;
   int lat = 0;
   ptpm_beat_type b, s, idle;
   initial begin
      ing_src = '0;
      eg_src = '0;
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      // idle data keeps moving so a stale byte is never mistaken for traffic
      idle = '{~cyc[7:0], 1'b0, 1'b0};
      b = idle;
      b.valid = (ti < 72);
      if (ti < 72) b.data = tx[ti];
      b.last = (ti == 71);
      ing_src <= sel ? idle : b;
      eg_src <= sel ? b : idle;
      if (go) ti <= 0;
      else if (ti < 72) ti <= ti + 1;
      if (ti == 0) t0 <= cyc;
      s = sel ? eg_snk : ing_snk;
      if (go) ri <= 0;
      else if (s.valid && ri < 72) begin
         rx[ri] <= s.data;
         ri <= ri + 1;
         if (ri == 0) lat <= cyc - t0 - 1;
      end
   end
endmodule // ptpm_far_model
`default_nettype wire

// file: ptpm_modifier.sv
// ptp on-the-fly packet modifier, ingress and egress byte paths
// What this block does
// - keep a bad incoming fcs unchanged
// - recompute fcs on every edited frame that arrived with a good fcs
// - fix v2 udp6 trailer bytes for checksum
// - no edits to v1 over udp6
// - keep max correction, saturate overflow to max
// - zero udp4 checksum whenever modifier not disabled and an ingress, egress or clear enable delays the path
// - same zeroing for ces frames when top mode
// - no correction edits on v1 messages
// - ingress enables insert 40-byte 320 ns delay
// - seconds select none, 8, 32 or 48 bits
// - seconds byte offset from header start
// - nanoseconds in low 30 of 4 bytes
// - stamps written most significant byte first
// - clear inserts zero stamp bytes on egress
// - egress enables insert 40-byte 320 ns delay
// - one-step sync writes origin timestamp
// - pdelay_resp adds egress minus pdelay_req stamp
// - latch each ingress pdelay_req stamp
// - delay/pdelay_req add ns plus 4 sec lsbs
`timescale 1ns/1ns
`default_nettype none
module ptpm_modifier import ptpm_pkg::*; (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire ptpm_beat_type ing_in,
   input wire ptpm_class_type ing_cls,
   output ptpm_beat_type ing_out,
   input wire ptpm_beat_type eg_in,
   input wire ptpm_class_type eg_cls,
   output ptpm_beat_type eg_out,
   input wire logic [47:0] tod_sec,
   input wire logic [29:0] tod_ns
);
   // ****************************************
   // helpers
   // ****************************************
   // crc registers hold the complement so that an all-zero reset is the seed
   function automatic logic [31:0] crc_byte(logic [31:0] c, logic [7:0] b);
      logic [31:0] x;
      x = c ^ {24'h00_0000, b};
      for (int i = 0; i < 8; i++) begin
         x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
      end
      return x;
   endfunction
   function automatic logic [15:0] add1c(logic [15:0] a, logic [15:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[15:0] + {15'h0000, s[16]};
   endfunction
   function automatic logic [7:0] pick(logic [63:0] v, int k);
      return 8'(v >> (8 * k));
   endfunction
   function automatic logic signed [11:0] sec_bytes(logic [1:0] sel);
      case (sel)
         2'h0: return 12'sd0;
         2'h1: return 12'sd1;
         2'h2: return 12'sd4;
         default: return 12'sd6;
      endcase
   endfunction
   function automatic logic [63:0] cf_sat(logic [63:0] cf, logic [63:0] a);
      logic [64:0] s;
      s = {cf[63], cf} + {a[63], a};
      if (cf == CF_MAX) return cf;
      if (s[64] != s[63]) return CF_MAX;
      return s[63:0];
   endfunction

   localparam int DLY = BUF_CYC + 1;
   ptpm_state_type s_r, s_nxt;
   logic ing_dly, eg_dly;
   logic [1:0] h_fcs, h_cf, h_z, h_ins;
   logic signed [11:0] orel [2];
   logic signed [11:0] so_chk, no_chk;

   assign ing_dly = |s_r.ctrl[C_ING +: 4];
   assign eg_dly = |s_r.ctrl[C_EGR +: 4] | s_r.ctrl[C_CLR];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_r.rdata;
   assign ing_out = s_r.dir[0].out;
   assign eg_out = s_r.dir[1].out;

   // ****************************************
   // datapath and register file
   // ****************************************
   always_comb begin
      ptpm_beat_type b;
      ptpm_class_type c;
      logic dly, mod, q, ins, eon, tv, tl;
      logic [7:0] t, o;
      logic signed [11:0] rel, so, no, nb, ml;
      logic [63:0] v;
      logic [15:0] fix;
      logic [31:0] r;
      s_nxt = s_r;
      b = '0;
      c = '0;
      {dly, mod, q, ins, eon, tv, tl} = '0;
      {t, o, fix, v, r} = '0;
      {rel, so, no, nb, ml} = '0;
      {h_fcs, h_cf, h_z, h_ins} = '0;
      orel[0] = '0;
      orel[1] = '0;
      so = 12'(s_r.place[P_SOFF +: 6]);
      no = 12'(s_r.place[P_NOFF +: 6]);
      nb = sec_bytes(s_r.place[P_SSEL +: 2]);
      for (int d = 0; d < 2; d++) begin
         b = (d == 0) ? ing_in : eg_in;
         c = (d == 0) ? ing_cls : eg_cls;
         dly = (d == 0) ? ing_dly : eg_dly;
         // input side: original correction and incoming fcs check
         if (b.valid) begin
            rel = 12'(s_r.dir[d].in_pos) - 12'(c.hdr_start);
            if (rel >= OFF_CF && rel < OFF_CF + CF_BYTES) begin
               s_nxt.dir[d].cf_in = {s_r.dir[d].cf_in[55:0], b.data};
            end
            s_nxt.dir[d].icrc = ~crc_byte(~s_r.dir[d].icrc, b.data);
            s_nxt.dir[d].in_pos = s_r.dir[d].in_pos + 1'b1;
            if (b.last) begin
               s_nxt.dir[d].len = s_r.dir[d].in_pos + 1'b1;
               s_nxt.dir[d].fcs_good =
                  crc_byte(~s_r.dir[d].icrc, b.data) == CRC_RES;
               s_nxt.dir[d].icrc = '0;
               s_nxt.dir[d].in_pos = '0;
            end
         end
         // fixed-length delay line, one byte per clock
         s_nxt.dir[d].bytes = {s_r.dir[d].bytes[BUF_CYC-2:0], b.data};
         s_nxt.dir[d].bval = {s_r.dir[d].bval[BUF_CYC-2:0], b.valid};
         s_nxt.dir[d].blast = {s_r.dir[d].blast[BUF_CYC-2:0], b.last};
         t = s_r.dir[d].bytes[BUF_CYC-1];
         tv = s_r.dir[d].bval[BUF_CYC-1];
         tl = s_r.dir[d].blast[BUF_CYC-1];
         rel = 12'(s_r.dir[d].out_pos) - 12'(c.hdr_start);
         ml = 12'(s_r.dir[d].msglen);
         orel[d] = rel;
         mod = ~s_r.ctrl[C_DIS] & ~(c.ptp_udp6 & ~c.v2) & dly & tv;
         q = mod & c.qualified & ~c.msg_type[2];
         ins = (d == 0) ? q & s_r.ctrl[C_ING + int'(c.msg_type[1:0])]
                        : q & s_r.ctrl[C_CLR];
         eon = (d == 1) & q & s_r.ctrl[C_EGR + int'(c.msg_type[1:0])];
         h_ins[d] = ins;
         o = t;
         // inserted stamp, or its clearing on egress
         if (ins && rel >= so && rel < so + nb) begin
            o = (d == 0) ? pick(64'(s_r.dir[d].tsec), int'(nb - 1 - (rel - so)))
                         : 8'h00;
         end
         if (ins && s_r.place[P_NEN] && rel >= no && rel < no + NS_BYTES) begin
            o = (d == 0) ? pick(64'(s_r.dir[d].tns), int'(NS_BYTES - 1 - (rel - no)))
                         : 8'h00;
         end
         // one-step sync origin timestamp
         if (eon && c.msg_type == MT_SYNC) begin
            if (c.v2 && rel >= V2_OSEC && rel < V2_ONS) begin
               o = pick(64'(s_r.dir[d].tsec), V2_ONS - 1 - int'(rel));
            end
            if (c.v2 && rel >= V2_ONS && rel < V2_ONS + NS_BYTES) begin
               o = pick(64'(s_r.dir[d].tns), V2_ONS + NS_BYTES - 1 - int'(rel));
            end
            if (!c.v2 && rel >= V1_OSEC && rel < V1_ONS) begin
               o = pick(64'(s_r.dir[d].tsec), V1_ONS - 1 - int'(rel));
            end
            if (!c.v2 && rel >= V1_ONS && rel < V1_ONS + NS_BYTES) begin
               o = pick(64'(s_r.dir[d].tns), V1_ONS + NS_BYTES - 1 - int'(rel));
            end
         end
         // correction: sec lsbs in ns plus ns, less pdelay_req stamp for resp
         if (c.msg_type == MT_PDRESP) begin
            v = 64'(4'(s_r.dir[d].tsec[3:0] - s_r.pd_sec)) * NS_PER_SEC
                + 64'(s_r.dir[d].tns) - 64'(s_r.pd_ns);
         end else begin
            v = 64'(s_r.dir[d].tsec[3:0]) * NS_PER_SEC
                + 64'(s_r.dir[d].tns);
         end
         h_cf[d] = eon & c.v2 & (c.msg_type != MT_SYNC) &
                   (rel >= OFF_CF) & (rel < OFF_CF + CF_BYTES);
         if (h_cf[d]) begin
            o = pick(cf_sat(s_r.dir[d].cf_in, v << CF_FRAC),
                     OFF_CF + CF_BYTES - 1 - int'(rel));
         end
         // the checksum leaves before qualification is known, so zero it
         h_z[d] = mod & (c.ptp_udp4 | (c.ces & s_r.ctrl[C_TOP])) &
                  (rel < 0) & (rel >= -UDP_CS_BACK);
         if (h_z[d]) begin
            o = 8'h00;
         end
         // udp6 trailer word absorbs every change made in the message
         if (mod && c.ptp_udp6) begin
            if (rel == OFF_LEN) begin
               s_nxt.dir[d].msglen[15:8] = t;
            end
            if (rel == OFF_LEN + 1) begin
               s_nxt.dir[d].msglen[7:0] = t;
            end
            if (rel >= 0 && rel < ml) begin
               s_nxt.dir[d].delta = add1c(add1c(s_r.dir[d].delta,
                  rel[0] ? {8'h00, t} : {t, 8'h00}),
                  ~(rel[0] ? {8'h00, o} : {o, 8'h00}));
            end
            if (rel == ml) begin
               fix = add1c({t, s_r.dir[d].bytes[BUF_CYC-2]}, s_r.dir[d].delta);
               o = fix[15:8];
               s_nxt.dir[d].fixlo = fix[7:0];
            end
            if (rel == ml + 1) begin
               o = s_r.dir[d].fixlo;
            end
         end
         // frame check: replaced only when it arrived good
         h_fcs[d] = dly & tv & s_r.dir[d].fcs_good &
                    (s_r.dir[d].out_pos + POS_W'(FCS_BYTES) >= s_r.dir[d].len);
         if (h_fcs[d]) begin
            o = pick(64'(s_r.dir[d].ocrc), int'(s_r.dir[d].out_pos + POS_W'(FCS_BYTES)
                     - s_r.dir[d].len));
         end else if (tv) begin
            s_nxt.dir[d].ocrc = ~crc_byte(~s_r.dir[d].ocrc, o);
         end
         if (tv && s_r.dir[d].out_pos == '0) begin
            s_nxt.dir[d].tsec = tod_sec;
            s_nxt.dir[d].tns = tod_ns;
            s_nxt.dir[d].delta = '0;
         end
         if (tv) begin
            s_nxt.dir[d].out_pos = tl ? '0 : s_r.dir[d].out_pos + 1'b1;
         end
         if (tv && tl) begin
            s_nxt.dir[d].ocrc = '0;
         end
         if (d == 0 && tv && tl && c.qualified && c.v2 && c.msg_type == MT_PDREQ) begin
            s_nxt.pd_sec = s_r.dir[d].tsec[3:0];
            s_nxt.pd_ns = s_r.dir[d].tns;
         end
         s_nxt.dir[d].out = dly ? ptpm_beat_type'{data: o, valid: tv, last: tl}
                                : b;
      end
      // ahb-lite: write in data phase, read sampled after that write
      if (s_r.awr && s_r.aaddr == A_CTRL) begin
         s_nxt.ctrl = hwdata & CTRL_MASK;
      end
      if (s_r.awr && s_r.aaddr == A_PLACE) begin
         s_nxt.place = hwdata & PLACE_MASK;
      end
      case (haddr[7:0])
         A_CTRL: r = s_nxt.ctrl;
         A_PLACE: r = s_nxt.place;
         A_STAT: r = {24'h00_0000, s_r.pd_sec, 2'b00, eg_dly, ing_dly};
         A_PDNS: r = {2'b00, s_r.pd_ns};
         default: r = '0;
      endcase
      s_nxt.awr = hsel & hready & htrans[1] & hwrite;
      s_nxt.aaddr = haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite) begin
         s_nxt.rdata = r;
      end
   end

   always_ff @(posedge core_clk) begin
      s_r <= srst ? '0 : s_nxt;
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   AST_FCS_KEEP: assert property (eg_dly && s_r.dir[1].bval[BUF_CYC-1] &&
      s_r.dir[1].blast[BUF_CYC-1] && !s_r.dir[1].fcs_good
      |=> eg_out.data == $past(s_r.dir[1].bytes[BUF_CYC-1]))
      else $error("bad fcs was altered");
   AST_FCS_NEW: assert property (h_fcs[1] && s_r.dir[1].blast[BUF_CYC-1]
      |=> eg_out.data == $past(s_r.dir[1].ocrc[31:24]) && eg_out.last)
      else $error("last fcs byte not recomputed");
   AST_V1_UDP6: assert property (eg_dly && eg_cls.ptp_udp6 && !eg_cls.v2 &&
      s_r.dir[1].bval[BUF_CYC-1] && !h_fcs[1]
      |=> eg_out.data == $past(s_r.dir[1].bytes[BUF_CYC-1]))
      else $error("v1 udp6 frame edited");
   AST_CF_MAX: assert property (h_cf[1] && s_r.dir[1].cf_in == CF_MAX &&
      !h_fcs[1] |=> eg_out.data == $past(s_r.dir[1].bytes[BUF_CYC-1]))
      else $error("max correction changed");
   AST_UDP_ZERO: assert property ((h_z[1] && !h_fcs[1]) ##1
      (h_z[1] && !h_fcs[1]) |=> eg_out.data == 8'h00 && $past(eg_out.data) == 8'h00)
      else $error("udp checksum not zeroed");
   AST_CF_V1: assert property ((h_cf[0] || h_cf[1]) |-> !h_cf[0] && eg_cls.v2)
      else $error("correction edit on v1 or ingress");
   AST_ING_DLY: assert property (ing_dly && $past(ing_dly, DLY)
      |-> ing_out.valid == $past(ing_in.valid, DLY))
      else $error("ingress delay not 40 bytes");
   AST_ING_PASS: assert property (!ing_dly |=> ing_out == $past(ing_in))
      else $error("ingress not passed straight");
   AST_EG_DLY: assert property (eg_dly && $past(eg_dly, DLY)
      |-> eg_out.last == $past(eg_in.last, DLY))
      else $error("egress delay not 40 bytes");
   AST_SEC_LSB: assert property (h_ins[0] && s_r.place[P_SSEL +: 2] == 2'h1 &&
      orel[0] == so_chk && !h_fcs[0] && !h_z[0] && !h_cf[0]
      |=> ing_out.data == $past(s_r.dir[0].tsec[7:0]))
      else $error("seconds lsb byte misplaced");
   AST_NS_TOP: assert property (h_ins[0] && s_r.place[P_NEN] &&
      orel[0] == no_chk && !h_fcs[0] |=> ing_out.data[7:6] == 2'b00)
      else $error("nanos upper bits not zero");
   AST_CLR: assert property (h_ins[1] && s_r.place[P_NEN] && orel[1] == no_chk &&
      !h_fcs[1] && !h_cf[1] |=> eg_out.data == 8'h00)
      else $error("egress stamp byte not cleared");
   AST_PDREQ: assert property (s_r.dir[0].bval[BUF_CYC-1] &&
      s_r.dir[0].blast[BUF_CYC-1] && ing_cls.qualified && ing_cls.v2 &&
      ing_cls.msg_type == MT_PDREQ |=> s_r.pd_ns == $past(s_r.dir[0].tns))
      else $error("pdelay_req stamp not latched");
   COV_CF: cover property (h_cf[1] ##1 h_cf[1]);
   COV_INS: cover property (h_ins[0] && s_r.place[P_NEN]);
   COV_FCS: cover property (h_fcs[1] && s_r.dir[1].blast[BUF_CYC-1]);
   COV_ZERO: cover property (h_z[0] || h_z[1]);

   assign so_chk = 12'(s_r.place[P_SOFF +: 6]);
   assign no_chk = 12'(s_r.place[P_NOFF +: 6]);
endmodule // ptpm_modifier
`default_nettype wire

// file: ptpm_pkg.sv
// constants and carrier types for the ptp on-the-fly packet modifier
package ptpm_pkg;
   // ****************************************
   // timing and sizes
   // ****************************************
   localparam int CLK_NS = 8;
   localparam int BUF_DELAY_NS = 320;
   localparam int BUF_CYC = BUF_DELAY_NS / CLK_NS;
   localparam int POS_W = 11;
   localparam int FCS_BYTES = 4;
   localparam int NS_BYTES = 4;
   localparam int UDP_CS_BACK = 2;
   // ****************************************
   // register map and fields
   // ****************************************
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_PLACE = 8'h04;
   localparam logic [7:0] A_STAT = 8'h08;
   localparam logic [7:0] A_PDNS = 8'h0C;
   localparam logic [31:0] CTRL_MASK = 32'h0000_FF07;
   localparam logic [31:0] PLACE_MASK = 32'h3F01_3F03;
   localparam int C_DIS = 0;
   localparam int C_TOP = 1;
   localparam int C_CLR = 2;
   localparam int C_ING = 8;
   localparam int C_EGR = 12;
   localparam int P_SSEL = 0;
   localparam int P_SOFF = 8;
   localparam int P_NEN = 16;
   localparam int P_NOFF = 24;
   // ****************************************
   // message layout and arithmetic
   // ****************************************
   localparam int OFF_LEN = 2;
   localparam int OFF_CF = 8;
   localparam int CF_BYTES = 8;
   localparam int CF_FRAC = 16;
   localparam int V2_OSEC = 34;
   localparam int V2_ONS = 40;
   localparam int V1_OSEC = 40;
   localparam int V1_ONS = 44;
   localparam logic [2:0] MT_SYNC = 3'h0;
   localparam logic [2:0] MT_PDREQ = 3'h2;
   localparam logic [2:0] MT_PDRESP = 3'h3;
   localparam logic [63:0] CF_MAX = 64'h7FFF_FFFF_FFFF_FFFF;
   localparam logic [63:0] NS_PER_SEC = 64'h0000_0000_3B9A_CA00;
   localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
   localparam logic [31:0] CRC_RES = 32'hDEBB_20E3;
   // ****************************************
   // carriers and state
   // ****************************************
   typedef struct packed {
      logic [7:0] data;
      logic valid;
      logic last;
   } ptpm_beat_type;
   typedef struct packed {
      logic ptp_udp4;
      logic ptp_udp6;
      logic ces;
      logic qualified;
      logic v2;
      logic [2:0] msg_type;
      logic [7:0] hdr_start;
   } ptpm_class_type;
   typedef struct packed {
      logic [BUF_CYC-1:0][7:0] bytes;
      logic [BUF_CYC-1:0] bval;
      logic [BUF_CYC-1:0] blast;
      logic [POS_W-1:0] in_pos, out_pos, len;
      logic [31:0] icrc, ocrc;
      logic fcs_good;
      logic [63:0] cf_in;
      logic [47:0] tsec;
      logic [29:0] tns;
      logic [15:0] delta, msglen;
      logic [7:0] fixlo;
      ptpm_beat_type out;
   } ptpm_dir_type;
   typedef struct packed {
      ptpm_dir_type [1:0] dir;
      logic [31:0] ctrl, place, rdata;
      logic [7:0] aaddr;
      logic awr;
      logic [3:0] pd_sec;
      logic [29:0] pd_ns;
   } ptpm_state_type;
endpackage
